// *** tempo_sync_pattern_generator_bench.sv ***
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin \
   mismatches++; $display("BAD %s exp %h got %h", nm, e, s); end end
module tempo_sync_pattern_generator_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PER = 40;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, run = 0;
   logic        jsel = 0, jp = 0, ri = 0, ro = 0, mk = 0, tap = 0;
   logic        lr = 0, sr = 0, gc = 0, gl = 0, ext = 0, arm = 0;
   logic        riq = 0, roq = 0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  h = 3'h0;
   logic [7:0]  rm = 8'h00, tq = 8'h00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, d;
   wire         hrdy, line, so, rpo, rjo, pu, gate;
   wire  [31:0] hrdata;
   wire  [7:0]  tw;
   wire  [1:0]  tled, lled;
   int          mismatches = 0, samples_checked = 0, n, i;
   int          seed = 32'h700669e5;
   tsp_clk_src src_m (.clk(hclk), .run(run), .half(8'h05), .line(line));
   tsp_core #(.TIMEOUT_CYC(32'hc8), .INT_PERIOD_CYC(32'h28),
      .LFO_FREE_THR(32'h40)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hrdy), .hreadyout(hrdy),
      .hresp(), .hrdata, .sync_jack_l_in(jsel & line),
      .sync_patch_in(~jsel & line), .sync_jack_present_in(jp),
      .sync_out(so), .sync_in_r_jack_in(ri), .sync_in_r_patch_out(rpo),
      .sync_out_r_patch_in(ro), .sync_out_r_jack_out(rjo), .mod_key_in(mk),
      .tap_in(tap), .slow_osc_phase_reset_in(lr), .slow_osc_rate_mod_in(rm),
      .slow_osc_triangle_out(tw), .slow_osc_pulse_out(pu), .seq_reset_in(sr),
      .gate_mod_conn_in(gc), .gate_mod_level_in(gl), .gate_out(gate),
      .cv_out(), .tempo_led_out(tled), .lfo_led_out(lled));
   initial forever #5 hclk = ~hclk;
   // ***************
   // free-running checks
   // ***************
   always @(posedge hclk) begin
      if (arm) begin
         `CHK("r_in", riq, rpo)
         `CHK("r_out", roq, rjo)
         if (ext) `CHK("thru", h[2], so)
         if (tw != tq && tw != 8'hff && tw != 8'h00)
            `CHK("pulse", tw > tq, pu)
      end
      arm <= hresetn;
      riq <= ri;
      roq <= ro;
      h <= {h[1:0], line};
      tq <= tw;
      ri <= $random(seed);
      ro <= $random(seed);
      rm <= $random(seed);
   end
   task wrap_up;
      if (mismatches == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task rdy;
      n = 0;
      do begin @(posedge hclk); n++; end while (hrdy !== 1'b1 && n < 100);
      if (n >= 100) begin mismatches++; wrap_up; end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy;
      q = hrdata;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      `CHK("reg", e, q)
   endtask
   task src(input logic [1:0] e);
      ahb(1'b0, tsp_pkg::OFF_STATUS, 32'h0);
      `CHK("src", e, q[1:0])
   endtask
   task wg(input logic v);
      n = 0;
      while (gate !== v && n < 400) begin @(posedge hclk); n++; end
      if (n >= 400) begin mismatches++; wrap_up; end
   endtask
   // ***************
   // main sequence
   // ***************
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(tsp_pkg::OFF_KNOB, 32'h80);
      rd(tsp_pkg::OFF_PATTERN, 32'h5555);
      rd(tsp_pkg::OFF_CTRL, 32'h0);
      rd(8'h40, 32'h0);
      for (i = 0; i < 4; i++) begin
         d = $random(seed);
         ahb(1'b1, tsp_pkg::OFF_PATTERN, d);
         rd(tsp_pkg::OFF_PATTERN, {16'h0, d[15:0]});
      end
      ahb(1'b1, tsp_pkg::OFF_PATTERN, 32'hffff);
      wg(1'b0);
      wg(1'b1);
      n = 0;
      while (gate === 1'b1 && n < 400) begin @(posedge hclk); n++; end
      `CHK("gate_len", 3 * PER / 4, n)
      gc <= 1'b1;
      repeat (8) @(posedge hclk);
      n = 0;
      repeat (120) begin @(posedge hclk); if (gate !== 1'b0) n++; end
      `CHK("invert", 0, n)
      gl <= 1'b1;
      repeat (60) @(posedge hclk);
      gc <= 1'b0;
      mk <= 1'b1;
      tap <= 1'b1;
      repeat (4) @(posedge hclk);
      tap <= 1'b0;
      repeat (56) @(posedge hclk);
      tap <= 1'b1;
      repeat (4) @(posedge hclk);
      tap <= 1'b0;
      repeat (200) @(posedge hclk);
      rd(tsp_pkg::OFF_PERIOD, 32'h3c);
      `CHK("tled", tsp_pkg::TSP_TLED_MAGENTA, tled)
      ahb(1'b1, tsp_pkg::OFF_KNOB, 32'h20);
      repeat (4) @(posedge hclk);
      `CHK("lled", tsp_pkg::TSP_LLED_COLD, lled)
      ahb(1'b1, tsp_pkg::OFF_KNOB, 32'hc0);
      repeat (4) @(posedge hclk);
      `CHK("lled", tsp_pkg::TSP_LLED_WARM, lled)
      run <= 1'b1;
      repeat (60) @(posedge hclk);
      src(tsp_pkg::TSP_SRC_PATCH);
      ext <= 1'b1;
      repeat (100) @(posedge hclk);
      ext <= 1'b0;
      run <= 1'b0;
      repeat (250) @(posedge hclk);
      src(tsp_pkg::TSP_SRC_INT);
      jp <= 1'b1;
      jsel <= 1'b1;
      ahb(1'b1, tsp_pkg::OFF_KNOB, 32'h00);
      run <= 1'b1;
      repeat (30) @(posedge hclk);
      src(tsp_pkg::TSP_SRC_JACK);
      `CHK("tled", tsp_pkg::TSP_TLED_CYAN, tled)
      ext <= 1'b1;
      repeat (230) @(posedge hclk);
      run <= 1'b0;
      repeat (250) @(posedge hclk);
      src(tsp_pkg::TSP_SRC_JACK);
      `CHK("step", 4'h0, q[7:4])
      rd(tsp_pkg::OFF_PERIOD, 32'h50);
      ext <= 1'b0;
      ahb(1'b1, tsp_pkg::OFF_CTRL, 32'h1);
      run <= 1'b1;
      repeat (40) @(posedge hclk);
      src(tsp_pkg::TSP_SRC_INT);
      `CHK("tled", tsp_pkg::TSP_TLED_ORANGE, tled)
      lr <= 1'b1;
      sr <= 1'b1;
      repeat (4) @(posedge hclk);
      `CHK("peak", 8'hff, tw)
      `CHK("peak_pulse", 1'b0, pu)
      wrap_up;
   end
endmodule

// *** tsp_clk_src.sv ***
module tsp_clk_src (
   // clock
   input  wire logic       clk,
   // burst control
   input  wire logic       run,
   input  wire logic [7:0] half,
   // clock line
   output logic            line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt = 8'h00;
   initial line = 1'b0;
   // a driven output, so it rests low between bursts rather than floating
   always @(posedge clk) begin
      if (!run) begin
         line <= 1'b0;
         cnt  <= 8'h00;
      end else if (cnt + 8'h01 >= half) begin
         line <= ~line;
         cnt  <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// *** tsp_core.sv ***
// Implementation choices: the placing of the registers and register access over AHB-Lite.
module tsp_core #(
   parameter logic [31:0] TIMEOUT_CYC    = tsp_pkg::TIMEOUT_CYC,
   parameter logic [31:0] INT_PERIOD_CYC = tsp_pkg::INT_PERIOD_CYC,
   parameter logic [31:0] LFO_FREE_THR   = tsp_pkg::LFO_FREE_THR
) (
   // ahb-lite slave
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // clock input and output
   input  wire logic        sync_jack_l_in,
   input  wire logic        sync_patch_in,
   input  wire logic        sync_jack_present_in,
   output logic             sync_out,
   // right channel pass-through
   input  wire logic        sync_in_r_jack_in,
   output logic             sync_in_r_patch_out,
   input  wire logic        sync_out_r_patch_in,
   output logic             sync_out_r_jack_out,
   // user controls
   input  wire logic        mod_key_in,
   input  wire logic        tap_in,
   // slow oscillator
   input  wire logic        slow_osc_phase_reset_in,
   input  wire logic [7:0]  slow_osc_rate_mod_in,
   output logic      [7:0]  slow_osc_triangle_out,
   output logic             slow_osc_pulse_out,
   // pattern generator
   input  wire logic        seq_reset_in,
   input  wire logic        gate_mod_conn_in,
   input  wire logic        gate_mod_level_in,
   output logic             gate_out,
   output logic      [7:0]  cv_out,
   // indicators
   output logic      [1:0]  tempo_led_out,
   output logic      [1:0]  lfo_led_out
);

   typedef struct packed {
      logic                ign;
      logic [7:0]          knob;
      logic [15:0]         pattern;
      logic [7:0]          cv_seed;
      logic                ah_we;
      logic [7:0]          ah_addr;
      logic [31:0]         rdata;
      tsp_pkg::tsp_src_e   src;
      logic [31:0]         since_ext;
      logic [31:0]         ext_per;
      logic [31:0]         int_per;
      logic [31:0]         int_cnt;
      logic [31:0]         tap_cnt;
      logic                tap_armed;
      logic [2:0]          tdiv;
      logic [2:0]          div_cnt;
      logic [2:0]          sub_n;
      logic [31:0]         mul_cnt;
      logic [31:0]         tick_per;
      logic [31:0]         tick_cnt;
      logic [3:0]          step;
      logic                gate;
      logic [7:0]          cv;
      logic [15:0]         lfsr;
      logic [7:0]          wave;
      logic                up;
      logic [31:0]         lfo_acc;
      logic                sync_o;
      logic                in_r;
      logic                out_r;
      tsp_pkg::tsp_tled_e  tled;
      tsp_pkg::tsp_lled_e  lled;
   } tsp_state_s;

   tsp_state_s s_r;
   tsp_state_s s_nxt;

   logic [tsp_pkg::IN_W-1:0] raw;
   logic [tsp_pkg::IN_W-1:0] lvl;
   logic [tsp_pkg::IN_W-1:0] rise;
   logic        ext_on;
   logic        e_any;
   logic        ext_lvl;
   logic        tick;
   logic        synced;
   logic        g;
   logic [3:0]  step_v;
   logic [2:0]  dsh;
   logic [2:0]  msh;
   logic [2:0]  div_lim;
   logic [31:0] gate_len;
   logic [31:0] lfo_thr;
   logic [12:0] rate_s;
   logic [31:0] rd_word;

   if (TIMEOUT_CYC < 32'd2 || INT_PERIOD_CYC < 32'd2 ||
       LFO_FREE_THR < 32'd1) begin : g_bad_par
      $error("tsp_core: timing parameters too small");
   end

   // ***********************************
   // input synchronisers
   // ***********************************
   assign raw = {gate_mod_level_in, gate_mod_conn_in, seq_reset_in,
                 slow_osc_phase_reset_in, mod_key_in, tap_in,
                 sync_jack_present_in, sync_patch_in, sync_jack_l_in};

   tsp_sync_edge #(.W(tsp_pkg::IN_W)) u_sync (
      .clk      (hclk),
      .rst_n    (hresetn),
      .d_in     (raw),
      .lvl_out  (lvl),
      .rise_out (rise)
   );

   // ***********************************
   // next state
   // ***********************************
   always_comb begin
      s_nxt   = s_r;
      tick    = 1'b0;
      g       = 1'b0;
      rd_word = '0;
      ext_on  = (s_r.src != tsp_pkg::TSP_SRC_INT);
      synced  = (s_r.knob < tsp_pkg::KNOB_CENTRE);

      // bus: writes land in the data phase, reads are sampled early
      if (s_r.ah_we) begin
         case (s_r.ah_addr)
            tsp_pkg::OFF_CTRL:    s_nxt.ign = hwdata[tsp_pkg::CTRL_IGN_BIT];
            tsp_pkg::OFF_KNOB:    s_nxt.knob = hwdata[7:0];
            tsp_pkg::OFF_PATTERN: s_nxt.pattern = hwdata[15:0];
            tsp_pkg::OFF_CV_SEED: s_nxt.cv_seed = hwdata[7:0];
            default: ;
         endcase
      end
      if (haddr[31:8] == 24'h00_0000) begin
         case (haddr[7:0])
            tsp_pkg::OFF_CTRL:    rd_word = {31'h0, s_r.ign};
            tsp_pkg::OFF_KNOB:    rd_word = {24'h0, s_r.knob};
            tsp_pkg::OFF_PATTERN: rd_word = {16'h0, s_r.pattern};
            tsp_pkg::OFF_CV_SEED: rd_word = {24'h0, s_r.cv_seed};
            tsp_pkg::OFF_STATUS: begin
               rd_word[tsp_pkg::ST_SRC_LSB +: 2]  = s_r.src;
               rd_word[tsp_pkg::ST_STEP_LSB +: 4] = s_r.step;
               rd_word[tsp_pkg::ST_GATE_BIT]      = s_r.gate;
               rd_word[tsp_pkg::ST_PULSE_BIT]     = s_r.up;
            end
            tsp_pkg::OFF_PERIOD:  rd_word = s_r.tick_per;
            default:              rd_word = '0;
         endcase
      end
      s_nxt.ah_we = 1'b0;
      if (hsel && hready && htrans[1]) begin
         s_nxt.ah_we   = hwrite && (haddr[31:8] == 24'h00_0000);
         s_nxt.ah_addr = haddr[7:0];
         if (!hwrite) begin
            s_nxt.rdata = rd_word;
         end
      end

      // source edges: the jack only ever looks at its left channel
      e_any   = lvl[tsp_pkg::IN_JP] ? rise[tsp_pkg::IN_JL]
                                    : rise[tsp_pkg::IN_PT];
      ext_lvl = lvl[tsp_pkg::IN_JP] ? lvl[tsp_pkg::IN_JL]
                                    : lvl[tsp_pkg::IN_PT];
      if (e_any) begin
         s_nxt.ext_per   = s_r.since_ext + 32'd1;
         s_nxt.since_ext = '0;
      end else if (s_r.since_ext != TIMEOUT_CYC) begin
         s_nxt.since_ext = s_r.since_ext + 32'd1;
      end

      case (s_r.src)
         tsp_pkg::TSP_SRC_INT: begin
            if (!s_r.ign && lvl[tsp_pkg::IN_JP]) begin
               s_nxt.src = tsp_pkg::TSP_SRC_JACK;
            end else if (!s_r.ign && rise[tsp_pkg::IN_PT]) begin
               s_nxt.src = tsp_pkg::TSP_SRC_PATCH;
            end
         end
         tsp_pkg::TSP_SRC_JACK: begin
            // no timeout here: a plugged jack waits forever
            if (s_r.ign || !lvl[tsp_pkg::IN_JP]) begin
               s_nxt.src = tsp_pkg::TSP_SRC_INT;
            end
         end
         tsp_pkg::TSP_SRC_PATCH: begin
            if (s_r.ign) begin
               s_nxt.src = tsp_pkg::TSP_SRC_INT;
            end else if (lvl[tsp_pkg::IN_JP]) begin
               s_nxt.src = tsp_pkg::TSP_SRC_JACK;
            end else if (s_r.since_ext == TIMEOUT_CYC) begin
               s_nxt.src = tsp_pkg::TSP_SRC_INT;
            end
         end
         default: s_nxt.src = tsp_pkg::TSP_SRC_INT;
      endcase

      // tap tempo; taps further apart than the timeout start over
      if (!lvl[tsp_pkg::IN_MOD]) begin
         s_nxt.tap_armed = 1'b0;
      end else if (rise[tsp_pkg::IN_TAP]) begin
         if (s_r.tap_armed) begin
            s_nxt.int_per = s_r.tap_cnt + 32'd1;
            s_nxt.int_cnt = '0;
         end
         s_nxt.tap_cnt   = '0;
         s_nxt.tap_armed = 1'b1;
      end else if (s_r.tap_armed) begin
         if (s_r.tap_cnt == TIMEOUT_CYC) begin
            s_nxt.tap_armed = 1'b0;
         end else begin
            s_nxt.tap_cnt = s_r.tap_cnt + 32'd1;
         end
      end

      // divider/multiplier latched from the knob while modifier held with an external source
      if (lvl[tsp_pkg::IN_MOD] && ext_on) begin
         s_nxt.tdiv = s_r.knob[7:5];
      end
      dsh = (s_r.tdiv <= tsp_pkg::TDIV_UNITY) ?
            3'(tsp_pkg::TDIV_UNITY - s_r.tdiv) : 3'h0;
      msh = (s_r.tdiv >= tsp_pkg::TDIV_MUL0) ?
            3'(s_r.tdiv - tsp_pkg::TDIV_MUL0) : 3'h0;
      div_lim = 3'((4'h1 << dsh) - 4'h1);

      // tempo tick from the chosen source
      if (ext_on) begin
         s_nxt.int_cnt = '0;
         if (e_any) begin
            s_nxt.mul_cnt = '0;
            s_nxt.sub_n   = '0;
            if (s_r.div_cnt >= div_lim) begin
               tick          = 1'b1;
               s_nxt.div_cnt = '0;
            end else begin
               s_nxt.div_cnt = s_r.div_cnt + 3'h1;
            end
         end else if (msh != 3'h0 &&
                      s_r.sub_n < 3'((4'h1 << msh) - 4'h1)) begin
            // extra ticks between edges, never one past the last
            s_nxt.mul_cnt = s_r.mul_cnt + 32'd1;
            if (s_r.mul_cnt + 32'd1 >= (s_r.ext_per >> msh)) begin
               tick          = 1'b1;
               s_nxt.mul_cnt = '0;
               s_nxt.sub_n   = s_r.sub_n + 3'h1;
            end
         end
      end else begin
         s_nxt.div_cnt = '0;
         if (s_r.int_cnt + 32'd1 >= s_r.int_per) begin
            tick          = 1'b1;
            s_nxt.int_cnt = '0;
         end else begin
            s_nxt.int_cnt = s_r.int_cnt + 32'd1;
         end
      end

      // clock out: thru when external, divider plays no part
      s_nxt.sync_o = ext_on ? ext_lvl
                   : (s_r.int_cnt < (s_r.int_per >> 1));

      // pattern generator
      gate_len = 32'(({2'b00, s_r.tick_per} * tsp_pkg::GATE_NUM)
                      >> tsp_pkg::GATE_SH);
      step_v = s_r.step;
      if (rise[tsp_pkg::IN_SRST]) begin
         step_v = '0;
      end
      s_nxt.lfsr = {s_r.lfsr[14:0], ^(s_r.lfsr & tsp_pkg::LFSR_TAPS)};
      if (tick) begin
         g = s_r.pattern[step_v];
         if (lvl[tsp_pkg::IN_GCON]) begin
            g = lvl[tsp_pkg::IN_GLVL] ? s_r.lfsr[0] : ~g;
         end
         s_nxt.gate     = g;
         s_nxt.cv       = {step_v, step_v} ^ s_r.cv_seed;
         s_nxt.step     = step_v + 4'h1;
         s_nxt.tick_per = s_r.tick_cnt + 32'd1;
         s_nxt.tick_cnt = '0;
      end else begin
         s_nxt.step     = step_v;
         s_nxt.tick_cnt = s_r.tick_cnt + 32'd1;
         if (s_r.tick_cnt + 32'd1 >= gate_len) begin
            s_nxt.gate = 1'b0;
         end
      end
      if (ext_on && !e_any && s_r.since_ext == TIMEOUT_CYC - 32'd1) begin
         s_nxt.step = '0;
      end

      // slow oscillator: modulation only adds a signed offset to the rate
      lfo_thr = synced ?
         32'(({3'b000, s_r.tick_per} << s_r.knob[6:5])
             >> tsp_pkg::LFO_SYNC_SH) : LFO_FREE_THR;
      rate_s = tsp_pkg::LFO_BASE
             + {{5{slow_osc_rate_mod_in[7]}}, slow_osc_rate_mod_in};
      if (!synced) begin
         rate_s = rate_s + 13'({6'h00, s_r.knob[6:0]}
                               << tsp_pkg::FREE_GAIN_SH);
      end
      if (rate_s[12] || rate_s == 13'h0000) begin
         rate_s = 13'h0001;
      end
      // at the centre the free rate is the base: slowest
      if (s_r.lfo_acc + {19'h0, rate_s} >= lfo_thr) begin
         s_nxt.lfo_acc = '0;
         if (s_r.up) begin
            if (s_r.wave == tsp_pkg::TRI_MAX) begin
               s_nxt.up   = 1'b0;
               s_nxt.wave = s_r.wave - 8'h01;
            end else begin
               s_nxt.wave = s_r.wave + 8'h01;
            end
         end else begin
            if (s_r.wave == 8'h00) begin
               s_nxt.up   = 1'b1;
               s_nxt.wave = 8'h01;
            end else begin
               s_nxt.wave = s_r.wave - 8'h01;
            end
         end
      end else begin
         s_nxt.lfo_acc = s_r.lfo_acc + {19'h0, rate_s};
      end
      if (rise[tsp_pkg::IN_LRST]) begin
         s_nxt.wave    = tsp_pkg::TRI_MAX;
         s_nxt.up      = 1'b0;
         s_nxt.lfo_acc = '0;
      end

      // indicators
      if (!lvl[tsp_pkg::IN_MOD]) begin
         s_nxt.tled = tsp_pkg::TSP_TLED_OFF;
      end else if (s_r.ign) begin
         s_nxt.tled = tsp_pkg::TSP_TLED_ORANGE;
      end else if (ext_on) begin
         s_nxt.tled = tsp_pkg::TSP_TLED_CYAN;
      end else begin
         s_nxt.tled = tsp_pkg::TSP_TLED_MAGENTA;
      end
      s_nxt.lled = synced ? tsp_pkg::TSP_LLED_COLD
                          : tsp_pkg::TSP_LLED_WARM;

      s_nxt.in_r  = sync_in_r_jack_in;
      s_nxt.out_r = sync_out_r_patch_in;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r         <= '0;
         s_r.knob    <= tsp_pkg::KNOB_RST;
         s_r.pattern <= tsp_pkg::PATTERN_RST;
         s_r.cv_seed <= tsp_pkg::CV_SEED_RST;
         s_r.int_per <= INT_PERIOD_CYC;
         s_r.tdiv    <= tsp_pkg::TDIV_UNITY;
         s_r.lfsr    <= tsp_pkg::LFSR_RST;
         s_r.up      <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   assign hreadyout             = 1'b1;
   assign hresp                 = 1'b0;
   assign hrdata                = s_r.rdata;
   assign sync_out              = s_r.sync_o;
   assign sync_in_r_patch_out   = s_r.in_r;
   assign sync_out_r_jack_out   = s_r.out_r;
   assign slow_osc_triangle_out = s_r.wave;
   assign slow_osc_pulse_out    = s_r.up;
   assign gate_out              = s_r.gate;
   assign cv_out                = s_r.cv;
   assign tempo_led_out         = s_r.tled;
   assign lfo_led_out           = s_r.lled;

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   ign_src_a: assert property (s_r.ign |=>
      s_r.src == tsp_pkg::TSP_SRC_INT)
      else $error("ignore mode left external source");
   jack_hold_a: assert property (
      (s_r.src == tsp_pkg::TSP_SRC_JACK && lvl[tsp_pkg::IN_JP] &&
       !s_r.ign) |=> s_r.src == tsp_pkg::TSP_SRC_JACK)
      else $error("jack source dropped while cable present");
   patch_back_a: assert property (
      (s_r.src == tsp_pkg::TSP_SRC_PATCH && !lvl[tsp_pkg::IN_JP] &&
       !s_r.ign && s_r.since_ext == TIMEOUT_CYC)
      |=> s_r.src == tsp_pkg::TSP_SRC_INT)
      else $error("patch clock timeout did not revert");
   tmo_step_a: assert property (
      (ext_on && !e_any && s_r.since_ext == TIMEOUT_CYC - 32'd1)
      |=> s_r.step == 4'h0)
      else $error("pattern not reset after clock loss");
   thru_a: assert property (
      (ext_on ##1 ext_on) |-> sync_out == $past(ext_lvl))
      else $error("clock output is not the incoming clock");
   tri_peak_a: assert property (
      rise[tsp_pkg::IN_LRST] |=> slow_osc_triangle_out ==
      tsp_pkg::TRI_MAX && !slow_osc_pulse_out)
      else $error("phase reset did not reach peak");
   pulse_dir_a: assert property (
      ($changed(slow_osc_triangle_out) && $past(slow_osc_pulse_out) &&
       !$past(rise[tsp_pkg::IN_LRST]) &&
       $past(slow_osc_triangle_out) != tsp_pkg::TRI_MAX)
      |-> slow_osc_triangle_out > $past(slow_osc_triangle_out))
      else $error("pulse high while triangle falls");
   seq_rst_a: assert property (
      (rise[tsp_pkg::IN_SRST] && !tick && !ext_on) |=> s_r.step == 4'h0)
      else $error("sequence reset ignored");
   gate_len_a: assert property (
      ($fell(gate_out) && !$past(tick))
      |-> $past(s_r.tick_cnt) + 32'd1 >= $past(gate_len))
      else $error("gate fell before three quarters of step");
   led_ign_a: assert property (
      (lvl[tsp_pkg::IN_MOD] && s_r.ign) |=>
      tempo_led_out == tsp_pkg::TSP_TLED_ORANGE)
      else $error("ignore indication not orange");
   aux_a: assert property (
      hresetn |=> sync_in_r_patch_out == $past(sync_in_r_jack_in))
      else $error("right channel not routed");

endmodule

// *** tsp_pkg.sv ***
package tsp_pkg;

   // ***********************************
   // register map
   // ***********************************
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_KNOB     = 8'h04;
   localparam logic [7:0]  OFF_PATTERN  = 8'h08;
   localparam logic [7:0]  OFF_CV_SEED  = 8'h0c;
   localparam logic [7:0]  OFF_STATUS   = 8'h10;
   localparam logic [7:0]  OFF_PERIOD   = 8'h14;
   localparam int          CTRL_IGN_BIT = 0;
   localparam int          ST_SRC_LSB   = 0;
   localparam int          ST_STEP_LSB  = 4;
   localparam int          ST_GATE_BIT  = 8;
   localparam int          ST_PULSE_BIT = 9;
   localparam logic [7:0]  KNOB_RST     = 8'h80;
   localparam logic [15:0] PATTERN_RST  = 16'h5555;
   localparam logic [7:0]  CV_SEED_RST  = 8'h00;

   // ***********************************
   // timing
   // ***********************************
   localparam longint CLK_HZ          = 100_000_000;
   localparam longint TIMEOUT_MS      = 2000;
   localparam longint INT_PERIOD_MS   = 500;
   localparam logic [31:0] TIMEOUT_CYC =
      32'((CLK_HZ * TIMEOUT_MS + 999) / 1000);
   localparam logic [31:0] INT_PERIOD_CYC =
      32'(CLK_HZ * INT_PERIOD_MS / 1000);
   localparam logic [31:0] LFO_FREE_THR = 32'h02fa_f080;

   // ***********************************
   // tempo, pattern and oscillator constants
   // ***********************************
   localparam logic [2:0]  TDIV_UNITY   = 3'h3;
   localparam logic [2:0]  TDIV_MUL0    = 3'h4;
   localparam logic [7:0]  KNOB_CENTRE  = 8'h80;
   localparam logic [7:0]  TRI_MAX      = 8'hff;
   localparam logic [12:0] LFO_BASE     = 13'h0040;
   localparam int          LFO_SYNC_SH  = 3;
   localparam int          FREE_GAIN_SH = 3;
   localparam logic [33:0] GATE_NUM     = 34'h3;
   localparam int          GATE_SH      = 2;
   localparam logic [15:0] LFSR_RST     = 16'hace1;
   localparam logic [15:0] LFSR_TAPS    = 16'hb400;

   // ***********************************
   // synchronised input indices
   // ***********************************
   localparam int IN_JL   = 0;
   localparam int IN_PT   = 1;
   localparam int IN_JP   = 2;
   localparam int IN_TAP  = 3;
   localparam int IN_MOD  = 4;
   localparam int IN_LRST = 5;
   localparam int IN_SRST = 6;
   localparam int IN_GCON = 7;
   localparam int IN_GLVL = 8;
   localparam int IN_W    = 9;

   typedef enum logic [1:0] {
      TSP_SRC_INT, TSP_SRC_JACK, TSP_SRC_PATCH
   } tsp_src_e;

   typedef enum logic [1:0] {
      TSP_TLED_OFF, TSP_TLED_CYAN, TSP_TLED_MAGENTA, TSP_TLED_ORANGE
   } tsp_tled_e;

   typedef enum logic [1:0] {
      TSP_LLED_OFF, TSP_LLED_COLD, TSP_LLED_WARM
   } tsp_lled_e;

endpackage

// *** tsp_sync_edge.sv ***
module tsp_sync_edge #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // raw inputs
   input  wire logic [W-1:0] d_in,
   // synchronised level and rising edge
   output logic      [W-1:0] lvl_out,
   output logic      [W-1:0] rise_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } tsp_sync_s;

   tsp_sync_s s_r;
   tsp_sync_s s_nxt;

   if (W < 1) begin : g_bad_w
      $error("tsp_sync_edge: W must be at least 1");
   end

   always_comb begin
      s_nxt    = s_r;
      s_nxt.s1 = d_in;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // s1 feeds only s2; everything downstream looks at s2 and s3
   assign lvl_out  = s_r.s2;
   assign rise_out = s_r.s2 & ~s_r.s3;

endmodule
